/* sector_guard_pkg.sv */
// Constants and carrier types for the tag sector protection and activity pin block.
// Assumes one 50 MHz clock domain; RF and I2C front ends deliver decoded one-cycle events.
package sector_guard_pkg;

    // ==========================================================
    // System area map
    localparam logic [11:0] WP_LOW_ADDR = 12'h800;
    localparam logic [11:0] WP_HIGH_ADDR = 12'h801;
    localparam logic [11:0] CFG_ADDR = 12'h910;
    localparam logic [11:0] CTRL_ADDR = 12'h920;
    localparam logic [15:0] WP_RESET = 16'h0000;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CFG_PIN_MODE_BIT = 3;
    localparam int CFG_HARVEST_MODE_BIT = 2;
    localparam int CTRL_HARVEST_BIT = 0;
    localparam int CTRL_FIELD_BIT = 1;
    localparam int CTRL_PROG_BIT = 7;
    localparam int SSS_LOCK_BIT = 0;
    localparam int SSS_RW_LSB = 1;
    localparam int SSS_PWD_LSB = 3;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic sof;
        logic crc_done;
        logic bad_cmd;
        logic exec_done;
        logic is_write;
        logic answer_start;
    } rf_events_t;

    typedef struct packed {
        logic valid;
        logic [1:0] pwd_id;
        logic correct;
    } rf_present_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic sys_sel;
        logic [11:0] addr;
        logic [7:0] wdata;
    } i2c_access_t;

    typedef enum logic [2:0] {
        PIN_IDLE = 3'b001,
        PIN_HOLD = 3'b010,
        PIN_WIP = 3'b100
    } pin_state_t;

endpackage : sector_guard_pkg

/* rf_activity_pin.sv */
// Open-drain activity pin sequencer in busy or write-in-progress mode.
// Assumes RF events are one-cycle pulses from the RF front end.
`timescale 1ns/100ps
module rf_activity_pin
    import sector_guard_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wip_mode,
    input wire logic i_field_on,
    input wire rf_events_t i_rf,
    output logic o_pin_oe
);

    // ==========================================================
    // State
    pin_state_t state_ff;
    pin_state_t nxt_state;
    logic oe_ff;
    logic nxt_oe;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PIN_IDLE: begin
                if (!i_wip_mode && i_rf.sof) begin
                    nxt_state = PIN_HOLD;
                end else if (i_wip_mode && i_rf.exec_done && i_rf.is_write
                             && !i_rf.bad_cmd) begin
                    nxt_state = PIN_WIP;
                end
            end
            PIN_HOLD: begin
                if (i_rf.exec_done || (i_rf.bad_cmd && i_rf.crc_done)) begin
                    nxt_state = PIN_IDLE;
                end
            end
            PIN_WIP: begin
                if (i_rf.answer_start) begin
                    nxt_state = PIN_IDLE;
                end
            end
            default: nxt_state = PIN_IDLE;
        endcase
        // Field loss ends any activity, and I2C traffic never starts one.
        if (!i_field_on) begin
            nxt_state = PIN_IDLE;
        end
        // Pin released in all other cases.
        nxt_oe = (nxt_state != PIN_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= PIN_IDLE;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            oe_ff <= nxt_oe;
        end
    end

    assign o_pin_oe = oe_ff;

endmodule : rf_activity_pin

/* tag_sector_protect_activity_pin.sv */
// Sector access control, system registers and activity pin of a dual-interface tag.
// Assumes decoded I2C byte accesses and RF events arrive as one-cycle pulses.
`timescale 1ns/100ps
module tag_sector_protect_activity_pin
    import sector_guard_pkg::*;
#(
    parameter int SECTORS = 16
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire i2c_access_t i_i2c,
    input wire logic i_i2c_pwd_ok,
    input wire logic [7:0] i_sector_status [SECTORS],
    input wire rf_present_t i_rf_present,
    input wire rf_events_t i_rf,
    input wire logic i_field_on,
    input wire logic i_prog_ok,
    input wire logic i_rf_cfg_wr,
    input wire logic [7:0] i_rf_cfg_data,
    input wire logic i_rf_harvest_wr,
    input wire logic i_rf_harvest_val,
    input wire logic [3:0] i_sector_sel,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_write_allowed,
    output logic [SECTORS-1:0] o_rf_read_ok,
    output logic [SECTORS-1:0] o_rf_write_ok,
    output logic [7:0] o_config,
    output logic o_harvest_enable,
    output logic o_rf_activity_pin_out,
    output logic o_rf_activity_pin_oe
);

    // ==========================================================
    // Register storage
    logic [15:0] wp_ff;
    logic [15:0] nxt_wp;
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic harvest_ff;
    logic nxt_harvest;
    logic boot_ff;
    logic nxt_boot;
    logic [2:0] pwd_open_ff;
    logic [2:0] nxt_pwd_open;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic wallow_ff;
    logic nxt_wallow;
    logic [SECTORS-1:0] rd_ok_ff;
    logic [SECTORS-1:0] nxt_rd_ok;
    logic [SECTORS-1:0] wr_ok_ff;
    logic [SECTORS-1:0] nxt_wr_ok;
    logic sys_wr;
    logic [7:0] ctrl_view;
    logic user_wr;
    logic [3:0] user_sector;

    assign sys_wr = i_i2c.req && i_i2c.wr && i_i2c.sys_sel;
    assign user_wr = i_i2c.req && i_i2c.wr && !i_i2c.sys_sel;
    assign user_sector = i_i2c.addr[10:7];
    assign ctrl_view = {i_prog_ok, 5'h00, i_field_on, harvest_ff};

    // ==========================================================
    // I2C system area and RF configuration writes
    always_comb begin
        nxt_wp = wp_ff;
        nxt_cfg = cfg_ff;
        nxt_harvest = harvest_ff;
        nxt_boot = 1'b0;
        nxt_rdata = 8'h00;
        nxt_rvalid = 1'b0;
        nxt_wallow = 1'b0;
        if (sys_wr) begin
            unique case (i_i2c.addr)
                WP_LOW_ADDR: begin
                    // Clearing is always honoured; setting waits for the password.
                    nxt_wp[7:0] = i_i2c_pwd_ok ? i_i2c.wdata : (wp_ff[7:0] & i_i2c.wdata);
                end
                WP_HIGH_ADDR: begin
                    nxt_wp[15:8] = i_i2c_pwd_ok ? i_i2c.wdata : (wp_ff[15:8] & i_i2c.wdata);
                end
                CFG_ADDR: nxt_cfg = i_i2c.wdata;
                CTRL_ADDR: nxt_harvest = i_i2c.wdata[CTRL_HARVEST_BIT];
                default: ;
            endcase
        end
        if (i_rf_cfg_wr) begin
            nxt_cfg = i_rf_cfg_data;
        end
        if (i_rf_harvest_wr) begin
            nxt_harvest = i_rf_harvest_val;
        end
        // Harvesting default takes the inverse of the stored mode bit once after reset release.
        if (boot_ff) begin
            nxt_harvest = !cfg_ff[CFG_HARVEST_MODE_BIT];
        end
        if (i_i2c.req && !i_i2c.wr && i_i2c.sys_sel) begin
            nxt_rvalid = 1'b1;
            unique case (i_i2c.addr)
                WP_LOW_ADDR: nxt_rdata = wp_ff[7:0];
                WP_HIGH_ADDR: nxt_rdata = wp_ff[15:8];
                CFG_ADDR: nxt_rdata = cfg_ff;
                CTRL_ADDR: nxt_rdata = ctrl_view;
                default: nxt_rdata = 8'h00;
            endcase
        end
        // The user-area write gate is answered per access.
        if (user_wr) begin
            nxt_wallow = !wp_ff[user_sector] || i_i2c_pwd_ok;
        end
    end

    // ==========================================================
    // RF password state and sector rights
    always_comb begin
        nxt_pwd_open = pwd_open_ff;
        if (i_rf_present.valid) begin
            if (i_rf_present.correct && i_rf_present.pwd_id != 2'b00) begin
                nxt_pwd_open = 3'b000;
                nxt_pwd_open[i_rf_present.pwd_id - 2'd1] = 1'b1;
            end else begin
                nxt_pwd_open = 3'b000;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < SECTORS; g++) begin : g_sector
            logic [1:0] pwd_sel;
            logic [1:0] rw_code;
            logic granted;
            assign pwd_sel = i_sector_status[g][SSS_PWD_LSB +: 2];
            assign rw_code = i_sector_status[g][SSS_RW_LSB +: 2];
            assign granted = (pwd_sel != 2'b00) && pwd_open_ff[pwd_sel - 2'd1];
            always_comb begin
                if (!i_sector_status[g][SSS_LOCK_BIT]) begin
                    nxt_rd_ok[g] = 1'b1;
                    nxt_wr_ok[g] = 1'b1;
                end else begin
                    nxt_rd_ok[g] = granted || rw_code[1] == 1'b0;
                    nxt_wr_ok[g] = granted ? (rw_code != 2'b11) : (rw_code == 2'b01);
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wp_ff <= WP_RESET;
            cfg_ff <= CFG_RESET;
            harvest_ff <= 1'b0;
            boot_ff <= 1'b1;
            pwd_open_ff <= 3'b000;
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
            wallow_ff <= 1'b0;
            rd_ok_ff <= '0;
            wr_ok_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            cfg_ff <= nxt_cfg;
            harvest_ff <= nxt_harvest;
            boot_ff <= nxt_boot;
            pwd_open_ff <= nxt_pwd_open;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            wallow_ff <= nxt_wallow;
            rd_ok_ff <= nxt_rd_ok;
            wr_ok_ff <= nxt_wr_ok;
        end
    end

    // ==========================================================
    // Activity pin
    rf_activity_pin u_pin (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_wip_mode(cfg_ff[CFG_PIN_MODE_BIT]),
        .i_field_on(i_field_on),
        .i_rf(i_rf),
        .o_pin_oe(o_rf_activity_pin_oe)
    );

    assign o_rdata = rdata_ff;
    assign o_rdata_valid = rvalid_ff;
    assign o_write_allowed = wallow_ff;
    assign o_rf_read_ok = rd_ok_ff;
    assign o_rf_write_ok = wr_ok_ff;
    assign o_config = cfg_ff;
    assign o_harvest_enable = harvest_ff;
    // Open drain: the pin only ever pulls low.
    assign o_rf_activity_pin_out = 1'b0;

endmodule : tag_sector_protect_activity_pin

/* tag_guard_checker_properties.sv */
// Checker for the activity pin sequencing and the system read answer.
// Assumes it is bound to the sector guard top module and sees its ports only.
`timescale 1ns/100ps
module tag_guard_checker
    import sector_guard_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire i2c_access_t i_i2c,
    input wire rf_events_t i_rf,
    input wire logic i_field_on,
    input wire logic [7:0] o_config,
    input wire logic o_rdata_valid,
    input wire logic o_rf_activity_pin_oe
);
    // ==========================================================
    // Properties.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic wip;
    logic oe;
    assign wip = o_config[3];
    assign oe = o_rf_activity_pin_oe;
    a_busy_set: assert property (i_field_on && !wip && i_rf.sof |=> oe)
        else $error("busy pin not pulled at frame start");
    a_busy_end: assert property (!wip && !i_rf.sof && i_rf.exec_done |=> !oe)
        else $error("busy pin not released after execution");
    a_bad_end: assert property (!wip && !i_rf.sof && i_rf.bad_cmd && i_rf.crc_done |=> !oe)
        else $error("busy pin held after bad command");
    a_field_cut: assert property (!i_field_on |=> !oe)
        else $error("pin held without field");
    a_i2c_quiet: assert property (!wip && !oe && i_i2c.req && !i_rf.sof |=> !oe)
        else $error("pin pulled by bus access");
    a_wip_set: assert property (i_field_on && wip && i_rf.exec_done && i_rf.is_write
        && !i_rf.bad_cmd && !i_rf.answer_start |=> oe)
        else $error("write pin not pulled");
    a_wip_end: assert property (wip && i_rf.answer_start && !i_rf.exec_done |=> !oe)
        else $error("write pin held after answer");
    a_wip_idle: assert property (wip && !oe && !i_rf.exec_done |=> !oe)
        else $error("write pin pulled outside a write");
    a_sys_read: assert property (i_i2c.req && i_i2c.sys_sel && !i_i2c.wr |=> o_rdata_valid)
        else $error("system read not answered");
    cover property (!wip && i_rf.sof ##1 oe);
    cover property (wip && i_rf.answer_start && oe);
    cover property (!i_field_on && oe);
endmodule : tag_guard_checker

bind tag_sector_protect_activity_pin tag_guard_checker chk_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_i2c(i_i2c), .i_rf(i_rf), .i_field_on(i_field_on), .o_config(o_config),
    .o_rdata_valid(o_rdata_valid), .o_rf_activity_pin_oe(o_rf_activity_pin_oe));

/* i2c_master_model.sv */
// Bus master side: decoded byte accesses and the pulled-up activity pin.
// Assumes requests launch at the falling clock edge as one-cycle pulses.
`timescale 1ns/100ps
module i2c_master_model
    import sector_guard_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_pin_oe,
    input wire logic i_pin_out,
    output i2c_access_t o_i2c,
    output logic o_pin_level
);
    // ==========================================================
    // Pin and access task.
    assign o_pin_level = i_pin_oe ? i_pin_out : 1'b1;
    initial o_i2c = '0;
    task automatic access(input logic wr, input logic sys, input logic [11:0] a,
                          input logic [7:0] d);
        @(negedge i_clk);
        o_i2c = '{1'b1, wr, sys, a, d};
        @(negedge i_clk);
        o_i2c.req = 1'b0;
        o_i2c.wdata = ~d;
    endtask : access
endmodule : i2c_master_model

/* tag_sector_protect_activity_pin_tb_top.sv */
// Self-checking bench for the write guard, system registers, RF rights and activity pin.
// Assumes the bus master model and the bound checker are compiled first.
`timescale 1ns/100ps
module tag_sector_protect_activity_pin_tb_top
    import sector_guard_pkg::*;
;
    // ==========================================================
    // Stimulus, reference model and checks.
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic pwd_ok = 1'b0;
    logic field_on = 1'b1;
    logic prog_ok = 1'b0;
    logic [7:0] sector_security_status [16];
    rf_present_t pres = '0;
    rf_events_t ev = '0;
    i2c_access_t bus;
    logic [7:0] rdata, cfg;
    logic rvalid, wr_ok, harvest, pin_out, pin_oe, pin_level;
    logic [15:0] rd_ok, wr_rt, rnd = 16'hd7c7, wp = 16'h0000;
    logic [7:0] tbl [8] = '{8'h82, 8'h19, 8'h83, 8'h06, 8'h10, 8'h82, 8'h60, 8'h38};
    int errors = 0, checks = 0, cycles = 0, opened = 0;
    tag_sector_protect_activity_pin dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_i2c(bus),
        .i_i2c_pwd_ok(pwd_ok), .i_sector_status(sector_security_status), .i_rf_present(pres), .i_rf(ev),
        .i_field_on(field_on), .i_prog_ok(prog_ok), .i_rf_cfg_wr(1'b0), .i_rf_cfg_data(8'h00),
        .i_rf_harvest_wr(1'b0), .i_rf_harvest_val(1'b0), .i_sector_sel(4'h0), .o_rdata(rdata),
        .o_rdata_valid(rvalid), .o_write_allowed(wr_ok), .o_rf_read_ok(rd_ok),
        .o_rf_write_ok(wr_rt), .o_config(cfg), .o_harvest_enable(harvest),
        .o_rf_activity_pin_out(pin_out), .o_rf_activity_pin_oe(pin_oe));
    i2c_master_model m_u (.i_clk(i_clk), .i_pin_oe(pin_oe), .i_pin_out(pin_out), .o_i2c(bus),
        .o_pin_level(pin_level));
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nx
    function automatic logic [1:0] rt(input logic [7:0] s, input logic [1:0] op);
        logic p;
        p = s[4:3] != 2'h0 && s[4:3] == op;
        if (!s[0]) return 2'h3;
        return {p || s[2:1] < 2'h2, p ? s[2:1] != 2'h3 : s[2:1] == 2'h1};
    endfunction : rt
    task automatic end_sim;
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        m_u.access(1'b0, 1'b1, a, 8'h00);
        cmp({rvalid, rdata}, {1'b1, e});
    endtask : rd
    task automatic present(input logic [1:0] id, input logic ok);
        @(negedge i_clk);
        pres = '{1'b1, id, ok};
        @(negedge i_clk);
        pres.valid = 1'b0;
        repeat (2) @(negedge i_clk);
        opened = ok ? id : 0;
        for (int s = 0; s < 16; s++) cmp({rd_ok[s], wr_rt[s]}, rt(sector_security_status[s], opened[1:0]));
    endtask : present
    task automatic rf(input rf_events_t e, input logic exp);
        @(negedge i_clk);
        ev = e;
        @(negedge i_clk);
        ev = '0;
        cmp(pin_level, !exp);
    endtask : rf
    initial forever #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        for (int s = 0; s < 16; s++) sector_security_status[s] = 8'h00;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk) i_reset = 1'b0;
        @(negedge i_clk);
        cmp(harvest, 1'b1);
        rd(12'h800, 8'h00);
        rd(12'h801, 8'h00);
        rd(12'h930, 8'h00);
        prog_ok = rnd[0];
        rd(12'h920, {prog_ok, 7'h03});
        m_u.access(1'b1, 1'b1, 12'h920, 8'h00);
        cmp(harvest, 1'b0);
        rd(12'h920, {prog_ok, 7'h02});
        m_u.access(1'b1, 1'b1, 12'h800, 8'hff);
        rd(12'h800, 8'h00);
        pwd_ok = 1'b1;
        rnd = nx(rnd);
        wp = rnd;
        m_u.access(1'b1, 1'b1, 12'h800, wp[7:0]);
        m_u.access(1'b1, 1'b1, 12'h801, wp[15:8]);
        rd(12'h800, wp[7:0]);
        rd(12'h801, wp[15:8]);
        pwd_ok = 1'b0;
        rnd = nx(rnd);
        m_u.access(1'b1, 1'b1, 12'h801, rnd[7:0]);
        wp[15:8] = wp[15:8] & rnd[7:0];
        rd(12'h801, wp[15:8]);
        for (int s = 0; s < 16; s++) begin
            m_u.access(1'b1, 1'b0, {1'b0, s[3:0], 7'h00}, rnd[7:0]);
            cmp(wr_ok, !wp[s]);
            cmp(pin_level, 1'b1);
        end
        for (int s = 0; s < 16; s++) begin
            rnd = nx(rnd);
            sector_security_status[s] = s == 0 ? 8'h01 : s < 5 ? 8'(7 + 2 * s) : rnd[7:0] & 8'h1f;
        end
        for (int p = 1; p < 4; p++) present(p[1:0], 1'b1);
        present(2'h1, 1'b0);
        rf(6'h20, 1'b1);
        field_on = 1'b0;
        @(negedge i_clk);
        cmp(pin_level, 1'b1);
        field_on = 1'b1;
        for (int m = 0; m < 2; m++) begin
            rnd = nx(rnd);
            m_u.access(1'b1, 1'b1, 12'h910, {rnd[7:4], m[0], rnd[2:0]});
            cmp(cfg, {rnd[7:4], m[0], rnd[2:0]});
            for (int k = 0; k < 8; k++) rf(tbl[k][7:2], tbl[k][1 - m]);
        end
        m_u.access(1'b1, 1'b0, 12'h000, 8'h00);
        cmp(pin_level, 1'b1);
        end_sim();
    end
endmodule : tag_sector_protect_activity_pin_tb_top
